// ==== hw/aoc_output_ctrl.sv ====
// Purpose: sample clock stabiliser, output mode selection and output word drive
// Assumes: all pin inputs are asynchronous to core_clk and sampled by it
// Notes: the forwarded clock is rebuilt from the sample clock at core_clk resolution
//
// Behaviour
// - After the sample clock changes rate or stops, the stabiliser needs 100 cycles to lock.
// - With the stabiliser on, an input duty of 30% to 70% is rebuilt to a steady half duty.
// - Stabiliser enable is the clock mode setting in serial style, else the chip-select strap.
// - Output mode is the output mode setting in serial style, else the serial-clock strap.
// - In parallel style only full-rate single-ended and double-rate differential can be chosen.
// - Full-rate single-ended mode drives all 14 bits in parallel with overflow and both clocks.
// - Double-rate single-ended mode puts two bits on each of 7 pins, plus overflow and clock.
// - Double-rate differential mode drives 7 two-bit data pairs plus overflow and clock pairs.
// - In both double-rate modes even bits go out while the clock is low, odd bits while high.
// - A low serial-clock strap in parallel style picks full-rate, a high one differential DDR.
// - In parallel style a low chip-select strap turns the stabiliser off, a high one on.
// - In full-rate mode the data changes together with the falling edge of the forwarded clock.
module aoc_output_ctrl
    import aoc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // sample clock pins
    input wire logic sample_clock_pos,
    input wire logic sample_clock_neg,
    // converter core result
    input wire logic [SAMPLE_BITS-1:0] core_sample_word,
    input wire logic core_overrange,
    // configuration straps and serial-written settings
    input wire logic config_style_strap,
    input wire logic chip_select_strap,
    input wire logic serial_clock_strap,
    input wire logic clock_mode_register,
    input wire logic [1:0] output_mode_register,
    // output drain control and status
    input wire logic drain_enable,
    output logic sample_ready,
    output logic stabiliser_locked,
    output logic [1:0] active_mode,
    // sample outputs
    output logic [SAMPLE_BITS-1:0] sample_word_bits,
    output logic [PAIR_COUNT-1:0] paired_bit_output_pos,
    output logic [PAIR_COUNT-1:0] paired_bit_output_neg,
    output logic range_overflow_flag_pos,
    output logic range_overflow_flag_neg,
    output logic forwarded_sample_clock_pos,
    output logic forwarded_sample_clock_neg
);
    // two-stage synchronisers for every pin input
    localparam int SYNC_W = SAMPLE_BITS + 6;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [SYNC_W-1:0] pin_raw;

    assign pin_raw = {core_sample_word, core_overrange, sample_clock_pos, sample_clock_neg,
                      config_style_strap, chip_select_strap, serial_clock_strap};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
        end
    end

    logic [SAMPLE_BITS-1:0] s_word;
    logic s_over;
    logic s_enc;
    logic s_parallel;
    logic s_cs;
    logic s_sck;
    assign s_word = sync_b[SYNC_W-1:6];
    assign s_over = sync_b[5];
    // the sample clock counts as high when its true pin is above its complement
    assign s_enc = sync_b[4] & ~sync_b[3];
    assign s_parallel = sync_b[2];
    assign s_cs = sync_b[1];
    assign s_sck = sync_b[0];

    // configuration selection
    logic dcs_enable;
    aoc_mode_e mode;
    always_comb begin
        dcs_enable = s_parallel ? s_cs : clock_mode_register;
        if (s_parallel) begin
            mode = s_sck ? AOC_OM_DDR_LVDS : AOC_OM_FULL;
        end else begin
            case (output_mode_register)
                OM_CODE_DDR_CMOS: mode = AOC_OM_DDR_CMOS;
                OM_CODE_DDR_LVDS: mode = AOC_OM_DDR_LVDS;
                default: mode = AOC_OM_FULL;
            endcase
        end
    end
    assign active_mode = mode;

    // stabiliser: period measurement, lock count and rebuilt clock
    logic enc_d;
    logic enc_rise;
    logic [PERIOD_W-1:0] since_edge;
    logic [PERIOD_W-1:0] period;
    logic [6:0] lock_cnt;
    logic rebuilt;
    logic [PERIOD_W-1:0] next_since_edge;
    logic [PERIOD_W-1:0] next_period;
    logic [6:0] next_lock_cnt;
    logic next_rebuilt;
    logic [PERIOD_W-1:0] delta;
    logic stopped;

    assign enc_rise = s_enc & ~enc_d;
    assign delta = (since_edge > period) ? since_edge - period : period - since_edge;
    assign stopped = (since_edge == STOP_LIMIT);

    always_comb begin
        next_since_edge = stopped ? since_edge : since_edge + 1'b1;
        next_period = period;
        next_lock_cnt = lock_cnt;
        next_rebuilt = rebuilt;
        if (enc_rise) begin
            next_since_edge = 8'h01;
            next_period = since_edge;
            next_rebuilt = 1'b1;
            if (delta > PERIOD_TOL) begin
                next_lock_cnt = '0;
            end else if (lock_cnt != DCS_LOCK_EDGES) begin
                next_lock_cnt = lock_cnt + 1'b1;
            end
        end else begin
            if (stopped) begin
                next_lock_cnt = '0;
                next_rebuilt = 1'b0;
            end
            // falls after half the measured period, whatever the input duty
            if (since_edge >= {1'b0, period[PERIOD_W-1:1]}) begin
                next_rebuilt = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_d <= 1'b0;
            since_edge <= STOP_LIMIT;
            period <= '0;
            lock_cnt <= '0;
            rebuilt <= 1'b0;
        end else begin
            enc_d <= s_enc;
            since_edge <= next_since_edge;
            period <= next_period;
            lock_cnt <= next_lock_cnt;
            rebuilt <= next_rebuilt;
        end
    end

    logic int_clk;
    logic int_valid;
    assign stabiliser_locked = (lock_cnt == DCS_LOCK_EDGES);
    assign int_valid = dcs_enable ? stabiliser_locked : !stopped;
    assign int_clk = dcs_enable ? rebuilt : s_enc;

    // sample buffer between capture and output drive
    aoc_stream_if #(.WIDTH(WORD_W)) fill_if ();
    aoc_stream_if #(.WIDTH(WORD_W)) drain_if ();

    assign fill_if.valid = enc_rise;
    assign fill_if.data = {s_over, s_word};
    assign sample_ready = fill_if.ready;

    aoc_sample_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .fill(fill_if),
        .drain(drain_if)
    );

    // output drive: a new word is taken as the internal clock falls
    logic int_d;
    logic int_fall;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] next_word;
    logic clk_out;
    logic next_clk_out;
    logic [SAMPLE_BITS-1:0] full_out;
    logic [SAMPLE_BITS-1:0] next_full_out;
    logic [PAIR_COUNT-1:0] pair_out;
    logic [PAIR_COUNT-1:0] next_pair_out;
    logic pair_lvds;
    logic next_pair_lvds;
    logic over_out;
    logic next_over_out;
    logic [SAMPLE_BITS-1:0] cur_bits;
    logic phase_high;

    assign int_fall = int_d & ~int_clk;
    assign drain_if.ready = int_fall && int_valid && drain_enable;

    always_comb begin
        next_word = word;
        if (drain_if.ready && drain_if.valid) begin
            next_word = drain_if.data;
        end
        cur_bits = next_word[SAMPLE_BITS-1:0];
        phase_high = int_clk;
        next_clk_out = int_valid & int_clk;
        next_over_out = next_word[SAMPLE_BITS];
        next_full_out = '0;
        next_pair_out = '0;
        next_pair_lvds = 1'b0;
        case (mode)
            AOC_OM_FULL: begin
                next_full_out = cur_bits;
            end
            AOC_OM_DDR_CMOS, AOC_OM_DDR_LVDS: begin
                for (int i = 0; i < PAIR_COUNT; i++) begin
                    next_pair_out[i] = phase_high ? cur_bits[2*i+1] : cur_bits[2*i];
                end
                next_pair_lvds = (mode == AOC_OM_DDR_LVDS);
            end
            default: begin
                next_full_out = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_d <= 1'b0;
            word <= WORD_RESET;
            clk_out <= 1'b0;
            full_out <= '0;
            pair_out <= '0;
            pair_lvds <= 1'b0;
            over_out <= 1'b0;
        end else begin
            int_d <= int_clk;
            word <= next_word;
            clk_out <= next_clk_out;
            full_out <= next_full_out;
            pair_out <= next_pair_out;
            pair_lvds <= next_pair_lvds;
            over_out <= next_over_out;
        end
    end

    assign sample_word_bits = full_out;
    assign paired_bit_output_pos = pair_out;
    assign paired_bit_output_neg = pair_lvds ? ~pair_out : '0;
    assign range_overflow_flag_pos = over_out;
    assign range_overflow_flag_neg = pair_lvds ? ~over_out : 1'b0;
    assign forwarded_sample_clock_pos = clk_out;
    assign forwarded_sample_clock_neg = ~clk_out;
endmodule : aoc_output_ctrl

// ==== shared/aoc_pkg.sv ====
// Purpose: shared constants and types for the converter output and clock control
// Assumes: core clock of 40 MHz; sample clock well below the core clock
// Notes: output mode codes are those of the 2-bit output mode setting
package aoc_pkg;
    localparam int CORE_CLK_PERIOD_NS = 25;
    localparam int SAMPLE_BITS = 14;
    localparam int PAIR_COUNT = 7;
    localparam int WORD_W = SAMPLE_BITS + 1;
    localparam int FIFO_DEPTH = 32;
    localparam int PERIOD_W = 8;
    localparam logic [PERIOD_W-1:0] STOP_LIMIT = 8'hFF;
    localparam logic [PERIOD_W-1:0] PERIOD_TOL = 8'h01;
    localparam logic [6:0] DCS_LOCK_EDGES = 7'h64;
    localparam logic [1:0] OM_CODE_FULL = 2'h0;
    localparam logic [1:0] OM_CODE_DDR_CMOS = 2'h1;
    localparam logic [1:0] OM_CODE_DDR_LVDS = 2'h2;
    localparam logic [WORD_W-1:0] WORD_RESET = 15'h0000;

    typedef enum logic [1:0] {
        AOC_OM_FULL,
        AOC_OM_DDR_CMOS,
        AOC_OM_DDR_LVDS
    } aoc_mode_e;
endpackage : aoc_pkg

// ==== shared/aoc_stream_if.sv ====
// Purpose: valid/ready word stream between the control block and its sample buffer
// Assumes: one clock for both ends
// Notes: a word moves on a clock edge where valid and ready are both high
interface aoc_stream_if #(
    parameter int WIDTH = 15
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : aoc_stream_if

// ==== hw/aoc_sample_fifo.sv ====
// Purpose: flip-flop word buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty come from pointers with one extra wrap bit
module aoc_sample_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // fill and drain sides
    aoc_stream_if.sink fill,
    aoc_stream_if.source drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;

    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign fill.ready = !full;
    assign drain.valid = !empty;
    assign drain.data = mem[rd_ptr[AW-1:0]];
    assign do_push = fill.valid && !full;
    assign do_pop = drain.ready && !empty;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (do_push) begin
            next_wr_ptr = wr_ptr + 1'b1;
        end
        if (do_pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage carries no reset; only written words are ever read
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= fill.data;
        end
    end
endmodule : aoc_sample_fifo

// ==== dv/aoc_output_ctrl_monitor.sv ====
// Purpose: port checks of the output control block
// Assumes: straps settle through two sync stages
// Notes: bound below the endmodule
module aoc_output_ctrl_monitor
    import aoc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // configuration
    input wire logic config_style_strap,
    input wire logic serial_clock_strap,
    input wire logic [1:0] output_mode_register,
    // outputs
    input wire logic [1:0] active_mode,
    input wire logic [SAMPLE_BITS-1:0] sample_word_bits,
    input wire logic [PAIR_COUNT-1:0] paired_bit_output_pos,
    input wire logic [PAIR_COUNT-1:0] paired_bit_output_neg,
    input wire logic range_overflow_flag_pos,
    input wire logic range_overflow_flag_neg,
    input wire logic forwarded_sample_clock_pos,
    input wire logic forwarded_sample_clock_neg
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_clk_inverse: assert property (
        forwarded_sample_clock_neg == !forwarded_sample_clock_pos) else $error("clock copy");
    chk_cmos_single: assert property (
        $fell(forwarded_sample_clock_pos) && active_mode == 2'h1 && $stable(active_mode)
        |-> sample_word_bits == 14'h0000 && paired_bit_output_neg == 7'h00)
        else $error("unused pins driven");
    chk_lvds_pairs: assert property (
        $fell(forwarded_sample_clock_pos) && active_mode == 2'h2 && $stable(active_mode)
        |-> paired_bit_output_neg == ~paired_bit_output_pos
            && range_overflow_flag_neg == !range_overflow_flag_pos)
        else $error("pair not complementary");
    chk_full_on_fall: assert property (
        active_mode == 2'h0 && $past(active_mode) == 2'h0 && $past(active_mode, 2) == 2'h0
        && $changed(sample_word_bits) |-> $fell(forwarded_sample_clock_pos))
        else $error("data moved off clock fall");
    chk_ddr_halves: assert property (
        active_mode != 2'h0 && $past(active_mode, 2) == active_mode
        && $changed(paired_bit_output_pos) |-> $changed(forwarded_sample_clock_pos))
        else $error("pairs moved off clock edge");
    chk_par_ddr: assert property (
        (config_style_strap && serial_clock_strap) [*4] |-> active_mode == 2'h2)
        else $error("high strap mode");
    chk_par_full: assert property (
        (config_style_strap && !serial_clock_strap) [*4] |-> active_mode == 2'h0)
        else $error("low strap mode");
    chk_ser_mode: assert property (
        (!config_style_strap) [*4] ##0 output_mode_register == 2'h1 |-> active_mode == 2'h1)
        else $error("setting mode");
endmodule : aoc_output_ctrl_monitor

bind aoc_output_ctrl aoc_output_ctrl_monitor aoc_output_ctrl_monitor_i (
    .core_clk, .rst_n, .config_style_strap, .serial_clock_strap, .output_mode_register,
    .active_mode, .sample_word_bits, .paired_bit_output_pos, .paired_bit_output_neg,
    .range_overflow_flag_pos, .range_overflow_flag_neg, .forwarded_sample_clock_pos,
    .forwarded_sample_clock_neg
);

// ==== dv/aoc_rx_model.sv ====
// Purpose: receiving logic that rebuilds words from the output lines
// Assumes: told the mode the converter runs in
// Notes: latches on each rise of the forwarded clock
module aoc_rx_model
    import aoc_pkg::*;
(
    // clock and setup
    input wire logic core_clk,
    input wire logic [1:0] rx_mode,
    // converter lines
    input wire logic [SAMPLE_BITS-1:0] sample_word_bits,
    input wire logic [PAIR_COUNT-1:0] paired_bit_output_pos,
    input wire logic range_overflow_flag_pos,
    input wire logic forwarded_sample_clock_pos,
    // rebuilt words
    output logic [WORD_W-1:0] rx_word,
    output int rx_count
);
    timeunit 1ns;
    timeprecision 100ps;
    logic seen;
    logic [PAIR_COUNT-1:0] low_half;
    always @(posedge core_clk) begin
        if (forwarded_sample_clock_pos && !seen) begin
            rx_word[SAMPLE_BITS] <= range_overflow_flag_pos;
            if (rx_mode == 2'h1 || rx_mode == 2'h2) begin
                for (int i = 0; i < PAIR_COUNT; i++) begin
                    rx_word[2*i] <= low_half[i];
                    rx_word[2*i+1] <= paired_bit_output_pos[i];
                end
            end else begin
                rx_word[SAMPLE_BITS-1:0] <= sample_word_bits;
            end
            rx_count <= rx_count + 1;
        end
        seen <= forwarded_sample_clock_pos;
        low_half <= paired_bit_output_pos;
    end
endmodule : aoc_rx_model

// ==== dv/tb.sv ====
// Purpose: self-checking bench of the output control block
// Assumes: 200 ns single-ended sample clock
// Notes: rebuilt words must count up by one
module tb
    import aoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_n, enc, cfg, cs, sck, cmr, drain, ovr, rdy, lck, ofp, ofn, fcp, fcn;
    logic [1:0] omr, am, rx_mode;
    logic [SAMPLE_BITS-1:0] word, sw, exp_w;
    logic [PAIR_COUNT-1:0] pp, pn;
    logic [WORD_W-1:0] rx_word;
    int rx_count, n_mismatch, samples_checked, skip, hi_ns, enc_rises;
    bit run;
    aoc_output_ctrl aoc_output_ctrl_i (
        .core_clk(core_clk), .rst_n(rst_n), .sample_clock_pos(enc), .sample_clock_neg(1'b0),
        .core_sample_word(word), .core_overrange(ovr), .config_style_strap(cfg),
        .chip_select_strap(cs), .serial_clock_strap(sck), .clock_mode_register(cmr),
        .output_mode_register(omr), .drain_enable(drain), .sample_ready(rdy),
        .stabiliser_locked(lck), .active_mode(am), .sample_word_bits(sw),
        .paired_bit_output_pos(pp), .paired_bit_output_neg(pn), .range_overflow_flag_pos(ofp),
        .range_overflow_flag_neg(ofn), .forwarded_sample_clock_pos(fcp),
        .forwarded_sample_clock_neg(fcn));
    aoc_rx_model aoc_rx_model_i (
        .core_clk(core_clk), .rx_mode(rx_mode), .sample_word_bits(sw),
        .paired_bit_output_pos(pp), .range_overflow_flag_pos(ofp),
        .forwarded_sample_clock_pos(fcp), .rx_word(rx_word), .rx_count(rx_count));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // 5 Msps sample clock; every edge lands 2 ns after a core clock rise
    initial begin
        enc = 1'b0;
        word = 14'h0000;
        ovr = 1'b0;
        hi_ns = 100;
        #14.5;
        forever begin
            if (run) begin
                enc = 1'b1;
                #(hi_ns);
                enc = 1'b0;
                word = word + 14'h0001;
                ovr = word[2];
                #(200 - hi_ns);
            end else begin
                #200;
            end
        end
    end
    always @(posedge enc) enc_rises++;
    always @(rx_count) begin
        if (skip > 0) skip--;
        else cmp({1'b0, rx_word}, {1'b0, exp_w[2], exp_w});
        exp_w = rx_word[SAMPLE_BITS-1:0] + 14'h0001;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : cyc
    // length in core cycles of the next full high phase of the forwarded clock
    task automatic hi_len(output int n);
        n = 0;
        for (int i = 0; i < 20 && fcp; i++) cyc(1);
        for (int i = 0; i < 20 && !fcp; i++) cyc(1);
        for (int i = 0; i < 20 && fcp; i++) begin
            n++;
            cyc(1);
        end
    endtask : hi_len
    task automatic conclude;
        if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic t_reset;
        cmp(16'(sw), 16'h0000);
        cmp({12'h000, fcp, fcn, lck, rdy}, 16'h0005);
    endtask : t_reset
    task automatic t_mode(input logic c, input logic k, input logic [1:0] m, input logic [1:0] e);
        int c0;
        cfg = c;
        sck = k;
        omr = m;
        rx_mode = e;
        skip = 4;
        cyc(5);
        cmp(16'(am), 16'(e));
        c0 = rx_count;
        cyc(200);
        cmp(16'(rx_count - c0 > 20), 16'h0001);
    endtask : t_mode
    task automatic t_fill;
        int c0;
        skip = 1000;
        drain = 1'b0;
        cyc(320);
        cmp(16'(rdy), 16'h0000);
        c0 = rx_count;
        skip = 1;
        drain = 1'b1;
        for (int i = 0; i < 400 && rx_count < c0 + 32; i++) cyc(1);
        skip = 2;
        cmp(16'(rx_count >= c0 + 32), 16'h0001);
        cyc(100);
    endtask : t_fill
    task automatic t_stab;
        int e0;
        int n;
        skip = 100000;
        rx_mode = 2'h0;
        cfg = 1'b1;
        sck = 1'b0;
        cs = 1'b1;
        hi_ns = 75;
        run = 1'b0;
        cyc(300);
        cmp(16'(lck), 16'h0000);
        e0 = enc_rises;
        run = 1'b1;
        for (int i = 0; i < 2000 && !lck; i++) cyc(1);
        n = enc_rises - e0;
        cmp(16'(n >= 100 && n <= 103), 16'h0001);
        hi_len(n);
        cmp(16'(n), 16'h0004);
        cs = 1'b0;
        cyc(20);
        hi_len(n);
        cmp(16'(n), 16'h0003);
        cfg = 1'b0;
        omr = 2'h0;
        cmr = 1'b1;
        cyc(20);
        hi_len(n);
        cmp(16'(n), 16'h0004);
        hi_ns = 100;
        cyc(400);
        skip = 2;
        cyc(100);
    endtask : t_stab
    initial begin
        #500000;
        n_mismatch++;
        conclude;
    end
    initial begin
        rst_n = 1'b0;
        cfg = 1'b0;
        cs = 1'b0;
        sck = 1'b0;
        cmr = 1'b0;
        omr = 2'h0;
        drain = 1'b1;
        rx_mode = 2'h0;
        skip = 3;
        cyc(5);
        t_reset;
        cyc(5);
        rst_n = 1'b1;
        run = 1'b1;
        t_mode(1'b0, 1'b0, 2'h0, 2'h0);
        t_mode(1'b0, 1'b0, 2'h1, 2'h1);
        t_mode(1'b0, 1'b0, 2'h2, 2'h2);
        t_mode(1'b0, 1'b0, 2'h3, 2'h0);
        t_mode(1'b1, 1'b1, 2'h1, 2'h2);
        t_mode(1'b1, 1'b0, 2'h1, 2'h0);
        t_fill;
        t_stab;
        conclude;
    end
endmodule : tb
